// ==== rtl/acp_pkg.sv ====
// How it works
// - Each frame fills a 15-bit shift register, and its last bit completes a 16-bit word; bit 15 picks the write kind.
// - Bit 15 low: bits 14-11 address a control register, bits 8-0 data.
// - Bit 15 high: bits 14-12 pick the channel, bits 11-0 load its code if address 0101 selects it as an output pin.
// - For 250 us after reset defaults load and writes are dropped.
// - Registers reset to zero; the pull-down register resets to 0x0FF.
// - Address 0001 selects and enables output-channel readback.
// - Address 0010 sets the channels in the conversion sequence.
// - Address 0011 holds the shared converter settings.
// - Address 0100 picks analog input pins, 0101 analog output pins.
// - Address 0111 sets deferred load mode and the register read back.
// - Address 1000 picks digital output pins and pin seven busy output.
// - Address 1001 sets levels on digital output pins.
// - Address 1010 picks digital input pins.
// - Address 1011 powers down output converters and switches the reference.
// - Address 1100 picks open-drain drive, 1101 high-impedance pins.
// - The decoded command executes when frame select returns high.
// - Selected readback shifts out during the next frame's 16 clocks.
// - Conversion results go out on data-out without a readback command.
// - Address 0000 changes nothing.
// - Writing 0x5AC to the reset register acts as a hardware reset, except that adc_chan keeps its value.
// - A frame select fall while idle with a channel selected starts the next conversion in the sequence.
package acp_pkg;
   // ----------------------------------------
   // Frame layout
   // ----------------------------------------
   localparam int FRAME_BITS = 16;
   localparam int KIND_BIT = 15;
   localparam int ADDR_HI = 14;
   localparam int ADDR_LO = 11;
   localparam int DATA_HI = 8;
   localparam int CH_HI = 14;
   localparam int CH_LO = 12;
   localparam int CODE_HI = 11;
   localparam int KEY_HI = 10;
   localparam logic [10:0] SRST_KEY = 11'h5AC;
   // ----------------------------------------
   // Register addresses
   // ----------------------------------------
   localparam logic [3:0] A_NOP = 4'h0;
   localparam logic [3:0] A_DAC_RB = 4'h1;
   localparam logic [3:0] A_SEQ = 4'h2;
   localparam logic [3:0] A_CTRL = 4'h3;
   localparam logic [3:0] A_ADC_PINS = 4'h4;
   localparam logic [3:0] A_DAC_PINS = 4'h5;
   localparam logic [3:0] A_PULLDOWN = 4'h6;
   localparam logic [3:0] A_LOAD_MODE = 4'h7;
   localparam logic [3:0] A_GPO_PINS = 4'h8;
   localparam logic [3:0] A_GPO_LEVELS = 4'h9;
   localparam logic [3:0] A_GPI_PINS = 4'hA;
   localparam logic [3:0] A_PWR_REF = 4'hB;
   localparam logic [3:0] A_DRIVE_TYPE = 4'hC;
   localparam logic [3:0] A_HIZ_PINS = 4'hD;
   localparam logic [3:0] A_RSVD = 4'hE;
   localparam logic [3:0] A_SRST = 4'hF;
   localparam logic [8:0] RST_ZERO = 9'h000;
   localparam logic [8:0] RST_PULLDOWN = 9'h0FF;
   // ----------------------------------------
   // Fields
   // ----------------------------------------
   localparam int LOCK_BIT = 7;
   localparam int ADC_RANGE_BIT = 5;
   localparam int DAC_RANGE_BIT = 4;
   localparam int RB_EN_BIT = 6;
   localparam int RB_ADDR_HI = 5;
   localparam int RB_ADDR_LO = 2;
   localparam logic [1:0] LOAD_DIRECT = 2'b00;
   localparam logic [1:0] LOAD_XFER = 2'b10;
   localparam logic [1:0] DAC_RB_ON = 2'b11;
   localparam int BUSY_EN_BIT = 8;
   localparam int REF_EN_BIT = 8;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_NS = 5;
   localparam int POWERUP_US = 250;
   localparam int POWERUP_CYCLES = (POWERUP_US * 1000) / CLK_NS;
   localparam int CONV_NS = 2000;
   localparam int CONV_CYCLES = (CONV_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [1:0] {
      ST_INIT = 2'b00,
      ST_IDLE = 2'b01,
      ST_CONV = 2'b11
   } acp_state_e;
endpackage

// ==== rtl/acp_xfer_if.sv ====
`timescale 1ns/1ps
interface acp_xfer_if;
   logic [15:0] rx_word;
   logic rx_tgl;
   logic [15:0] tx_word;
   logic sdo;
   modport link (output rx_word, output rx_tgl, output sdo, input tx_word);
   modport core (input rx_word, input rx_tgl, input sdo, output tx_word);
endinterface

// ==== rtl/acp_link.sv ====
`timescale 1ns/1ps
module acp_link
   import acp_pkg::*;
(
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic sync_b,
   input wire logic sdi,
   acp_xfer_if.link xf
);
   logic [4:0] bit_cnt;
   logic [14:0] shreg;
   logic shifted;
   logic sdo_bit;

   // ----------------------------------------
   // Receive on falling edges
   // ----------------------------------------
   // Frame select high clears the count, so no edge is needed between frames
   always_ff @(negedge sclk or negedge rst_b or posedge sync_b) begin
      if (!rst_b) begin
         bit_cnt <= 5'd0;
         shreg <= 15'h0000;
      end else if (sync_b) begin
         bit_cnt <= 5'd0;
         shreg <= 15'h0000;
      end else if (bit_cnt != 5'(FRAME_BITS)) begin
         shreg <= {shreg[13:0], sdi};
         bit_cnt <= bit_cnt + 5'd1;
      end
   end

   // Extra clocks past the 16th are ignored
   always_ff @(negedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         xf.rx_word <= 16'h0000;
         xf.rx_tgl <= 1'b0;
      end else if (!sync_b && bit_cnt == 5'(FRAME_BITS - 1)) begin
         xf.rx_word <= {shreg, sdi};
         xf.rx_tgl <= ~xf.rx_tgl;
      end
   end

   // ----------------------------------------
   // Transmit on rising edges
   // ----------------------------------------
   always_ff @(posedge sclk or negedge rst_b or posedge sync_b) begin
      if (!rst_b) begin
         shifted <= 1'b0;
         sdo_bit <= 1'b0;
      end else if (sync_b) begin
         shifted <= 1'b0;
         sdo_bit <= 1'b0;
      end else begin
         shifted <= 1'b1;
         sdo_bit <= (bit_cnt < 5'(FRAME_BITS)) ?
                    xf.tx_word[4'(5'd15 - bit_cnt)] : 1'b0;
      end
   end

   // MSB shows from the frame select fall, before any sclk edge
   assign xf.sdo = shifted ? sdo_bit : xf.tx_word[15];
endmodule // acp_link

// ==== rtl/acp_port.sv ====
`timescale 1ns/1ps
module acp_port
   import acp_pkg::*;
#(
   parameter int POWERUP_P = POWERUP_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic sync_b,
   input wire logic sdi,
   output logic sdo,
   input wire logic [11:0] adc_code,
   output logic [2:0] adc_chan,
   output logic conv_busy,
   output logic init_busy,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] pin_pulldown,
   output logic [7:0] pin_adc_sel,
   output logic [7:0] pin_dac_sel,
   output logic [7:0] pin_gpi_sel,
   output logic [7:0] dac_powerdown,
   output logic ref_enable,
   output logic adc_range,
   output logic dac_range,
   output logic [7:0][11:0] dac_level
);
   acp_xfer_if xf ();

   acp_link u_link (
      .rst_b (rst_b),
      .sclk (sclk),
      .sync_b (sync_b),
      .sdi (sdi),
      .xf (xf.link)
   );

   assign sdo = xf.sdo;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [8:0] reg_default(input logic [3:0] a);
      return (a == A_PULLDOWN) ? RST_PULLDOWN : RST_ZERO;
   endfunction

   function automatic logic is_pin_cfg(input logic [3:0] a);
      return (a == A_ADC_PINS) || (a == A_DAC_PINS) || (a == A_PULLDOWN) ||
             (a == A_GPO_PINS) || (a == A_GPI_PINS) || (a == A_DRIVE_TYPE) ||
             (a == A_HIZ_PINS);
   endfunction

   // Next selected channel after cur, wrapping; cur when none is set
   function automatic logic [2:0] next_chan(input logic [7:0] seq, input logic [2:0] cur);
      logic [2:0] res;
      logic [2:0] cand;
      logic found;
      res = cur;
      found = 1'b0;
      for (int k = 1; k <= 8; k++) begin
         cand = 3'(cur + 3'(k));
         if (!found && seq[cand]) begin
            res = cand;
            found = 1'b1;
         end
      end
      return res;
   endfunction

   // ----------------------------------------
   // Crossing from the link
   // ----------------------------------------
   logic [2:0] sync_pipe;
   logic [2:0] tgl_pipe;
   logic sync_hi;
   logic tgl_seen;
   logic sync_fall;
   logic arrive;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_pipe <= 3'b111;
         tgl_pipe <= 3'b000;
      end else begin
         sync_pipe <= {sync_pipe[1:0], sync_b};
         tgl_pipe <= {tgl_pipe[1:0], xf.rx_tgl};
      end
   end

   assign sync_fall = sync_hi && (sync_pipe[2] == sync_pipe[1]) && !sync_pipe[2];
   assign arrive = (tgl_pipe[2] == tgl_pipe[1]) && (tgl_pipe[2] != tgl_seen);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_hi <= 1'b1;
         tgl_seen <= 1'b0;
      end else begin
         if (sync_pipe[2] == sync_pipe[1]) begin
            sync_hi <= sync_pipe[2];
         end
         if (arrive) begin
            tgl_seen <= tgl_pipe[2];
         end
      end
   end

   // ----------------------------------------
   // Command capture and execution
   // ----------------------------------------
   acp_state_e state;
   logic [15:0] cmd_word;
   logic frame_pend;
   logic exec;
   logic exec_d;
   logic ctrl_wr;
   logic dac_wr;
   logic soft_rst;
   logic writable;
   logic conv_end;
   logic [3:0] addr;
   logic [8:0] wdata;
   logic [2:0] wch;
   logic [11:0] wcode;
   logic [15:0][8:0] cfg;
   logic [7:0][11:0] dac_in;
   logic [15:0] init_cnt;
   logic [8:0] conv_cnt;
   logic [2:0] seq_ptr;
   logic seq_armed;

   // A word waits until frame select is seen high again
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_word <= 16'h0000;
         frame_pend <= 1'b0;
      end else if (arrive) begin
         cmd_word <= xf.rx_word;
         frame_pend <= 1'b1;
      end else if (frame_pend && sync_hi) begin
         frame_pend <= 1'b0;
      end
   end

   assign exec = frame_pend && sync_hi && (state != ST_INIT);
   assign addr = cmd_word[ADDR_HI:ADDR_LO];
   assign wdata = cmd_word[DATA_HI:0];
   assign wch = cmd_word[CH_HI:CH_LO];
   assign wcode = cmd_word[CODE_HI:0];
   assign ctrl_wr = exec && !cmd_word[KIND_BIT];
   assign dac_wr = exec && cmd_word[KIND_BIT];
   assign soft_rst = ctrl_wr && (addr == A_SRST) &&
                     (cmd_word[KEY_HI:0] == SRST_KEY);
   // Pin configuration is frozen while the lock bit is set
   assign writable = (addr != A_NOP) && (addr != A_RSVD) && (addr != A_SRST) &&
                     !(cfg[A_CTRL][LOCK_BIT] && is_pin_cfg(addr));
   assign conv_end = (state == ST_CONV) && (conv_cnt == 9'd0);

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         exec_d <= 1'b0;
      end else begin
         exec_d <= exec && !soft_rst;
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 16; i++) begin
            cfg[i] <= reg_default(4'(i));
         end
      end else if (soft_rst) begin
         for (int i = 0; i < 16; i++) begin
            cfg[i] <= reg_default(4'(i));
         end
      end else if (ctrl_wr && writable) begin
         cfg[addr] <= wdata;
      end
   end

   // ----------------------------------------
   // Output channel codes
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dac_in <= '0;
      end else if (soft_rst) begin
         dac_in <= '0;
      end else if (dac_wr && cfg[A_DAC_PINS][wch]) begin
         dac_in[wch] <= wcode;
      end
   end

   // Deferred mode holds codes until a transfer write
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dac_level <= '0;
      end else if (soft_rst) begin
         dac_level <= '0;
      end else if (dac_wr && cfg[A_DAC_PINS][wch] &&
                   cfg[A_LOAD_MODE][1:0] == LOAD_DIRECT) begin
         dac_level[wch] <= wcode;
      end else if (ctrl_wr && addr == A_LOAD_MODE && wdata[1:0] == LOAD_XFER) begin
         dac_level <= dac_in;
      end
   end

   // ----------------------------------------
   // Power-up and conversion sequencing
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_INIT;
         init_cnt <= 16'h0000;
         conv_cnt <= 9'h000;
         adc_chan <= 3'h0;
      end else if (soft_rst) begin
         state <= ST_INIT;
         init_cnt <= 16'h0000;
         conv_cnt <= 9'h000;
      end else begin
         case (state)
            ST_INIT: begin
               if (init_cnt == 16'(POWERUP_P - 1)) begin
                  state <= ST_IDLE;
               end else begin
                  init_cnt <= init_cnt + 16'h0001;
               end
            end
            ST_IDLE: begin
               if (sync_fall && seq_armed) begin
                  state <= ST_CONV;
                  conv_cnt <= 9'(CONV_CYCLES - 1);
                  adc_chan <= seq_ptr;
               end
            end
            ST_CONV: begin
               if (conv_cnt == 9'h000) begin
                  state <= ST_IDLE;
               end else begin
                  conv_cnt <= conv_cnt - 9'h001;
               end
            end
            default: begin
               state <= ST_INIT;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         seq_ptr <= 3'h0;
         seq_armed <= 1'b0;
      end else if (soft_rst) begin
         seq_ptr <= 3'h0;
         seq_armed <= 1'b0;
      end else if (ctrl_wr && addr == A_SEQ) begin
         seq_armed <= |wdata[7:0];
         seq_ptr <= next_chan(wdata[7:0], 3'h7);
      end else if (conv_end) begin
         seq_ptr <= next_chan(cfg[A_SEQ][7:0], adc_chan);
      end
   end

   // ----------------------------------------
   // Word for the next frame
   // ----------------------------------------
   // Held steady between frames; the link samples it without a handshake
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         xf.tx_word <= 16'h0000;
      end else if (soft_rst) begin
         xf.tx_word <= 16'h0000;
      end else if (conv_end) begin
         xf.tx_word <= {1'b0, adc_chan, adc_code};
      end else if (exec_d) begin
         if (cfg[A_DAC_RB][4:3] == DAC_RB_ON) begin
            xf.tx_word <= {1'b1, cfg[A_DAC_RB][2:0], dac_in[cfg[A_DAC_RB][2:0]]};
         end else if (cfg[A_LOAD_MODE][RB_EN_BIT]) begin
            xf.tx_word <= {1'b0, cfg[A_LOAD_MODE][RB_ADDR_HI:RB_ADDR_LO], 2'b00,
                           cfg[cfg[A_LOAD_MODE][RB_ADDR_HI:RB_ADDR_LO]]};
         end else begin
            xf.tx_word <= 16'h0000;
         end
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   logic [7:0] next_pin_oe;
   logic [7:0] next_pin_out;

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         next_pin_out[i] = cfg[A_GPO_LEVELS][i];
         next_pin_oe[i] = cfg[A_GPO_PINS][i] && !cfg[A_HIZ_PINS][i] &&
                          (!cfg[A_DRIVE_TYPE][i] || !cfg[A_GPO_LEVELS][i]);
      end
      // Busy indicator is low while a conversion runs
      if (cfg[A_GPO_PINS][BUSY_EN_BIT]) begin
         next_pin_oe[7] = 1'b1;
         next_pin_out[7] = (state != ST_CONV);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_out <= 8'h00;
         pin_oe <= 8'h00;
         pin_pulldown <= 8'hFF;
         pin_adc_sel <= 8'h00;
         pin_dac_sel <= 8'h00;
         pin_gpi_sel <= 8'h00;
         dac_powerdown <= 8'h00;
         ref_enable <= 1'b0;
         adc_range <= 1'b0;
         dac_range <= 1'b0;
         conv_busy <= 1'b0;
         init_busy <= 1'b1;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         pin_pulldown <= cfg[A_PULLDOWN][7:0];
         pin_adc_sel <= cfg[A_ADC_PINS][7:0];
         pin_dac_sel <= cfg[A_DAC_PINS][7:0];
         pin_gpi_sel <= cfg[A_GPI_PINS][7:0];
         dac_powerdown <= cfg[A_PWR_REF][7:0];
         ref_enable <= cfg[A_PWR_REF][REF_EN_BIT];
         adc_range <= cfg[A_CTRL][ADC_RANGE_BIT];
         dac_range <= cfg[A_CTRL][DAC_RANGE_BIT];
         conv_busy <= (state == ST_CONV);
         init_busy <= (state == ST_INIT);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [15:0] age;
   logic [8:0] conv_age;

   // Cycles spent in the current conversion
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_age <= 9'h000;
      end else if (state != ST_CONV) begin
         conv_age <= 9'h000;
      end else begin
         conv_age <= conv_age + 9'h001;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         age <= 16'h0000;
      end else if (soft_rst) begin
         age <= 16'h0000;
      end else if (age != 16'hFFFF) begin
         age <= age + 16'h0001;
      end
   end

   a_powerup_wait: assert property (@(posedge ref_clk) disable iff (!rst_b)
      exec |-> age >= 16'(POWERUP_P))
      else $error("command executed during power-up");

   a_soft_reset_defaults: assert property (@(posedge ref_clk) disable iff (!rst_b)
      soft_rst |=> cfg[A_PULLDOWN] == RST_PULLDOWN && cfg[A_SEQ] == RST_ZERO &&
                   state == ST_INIT && dac_in == '0)
      else $error("soft reset did not restore defaults");

   a_nop_no_effect: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ctrl_wr && addr == A_NOP |=> $stable(cfg) && $stable(dac_level))
      else $error("no-operation write changed state");

   a_reserved_ignored: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ctrl_wr && addr == A_RSVD |=> $stable(cfg) && $stable(dac_in))
      else $error("reserved write changed state");

   a_seq_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ctrl_wr && addr == A_SEQ |=> cfg[A_SEQ] == $past(cmd_word[8:0]))
      else $error("sequence register not written");

   a_dac_direct_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
      dac_wr && cfg[A_DAC_PINS][wch] && cfg[A_LOAD_MODE][1:0] == LOAD_DIRECT
      |=> dac_level[$past(wch)] == $past(wcode))
      else $error("output code not loaded");

   a_dac_needs_pin: assert property (@(posedge ref_clk) disable iff (!rst_b)
      dac_wr && !cfg[A_DAC_PINS][wch] |=> $stable(dac_in))
      else $error("code loaded to a non-output channel");

   a_conv_length: assert property (@(posedge ref_clk) disable iff (!rst_b)
      conv_end |-> conv_age == 9'(CONV_CYCLES - 1))
      else $error("conversion length wrong");

   a_result_loaded: assert property (@(posedge ref_clk) disable iff (!rst_b)
      conv_end && !soft_rst |=> xf.tx_word == {1'b0, $past(adc_chan), $past(adc_code)})
      else $error("conversion result not queued");
endmodule // acp_port

// ==== dv/acp_host.sv ====
`timescale 1ns/1ps
module acp_host (
   output logic sclk,
   output logic sync_b,
   output logic sdi,
   input wire logic sdo
);
   logic [15:0] rd;
   initial begin
      sclk = 1'b1;
      sync_b = 1'b1;
      sdi = 1'b0;
   end
   // 12.5 MHz clock, stands high outside frames
   task automatic frame(input logic [15:0] w);
      sync_b = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdi = w[i];
         #40 sclk = 1'b0;
         rd[i] = sdo;
         #40 sclk = 1'b1;
      end
      #40 sync_b = 1'b1;
      // Released line shows no stale bit
      sdi = ~sdi;
   endtask
endmodule // acp_host

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic ref_clk, rst_b, sclk, sync_b, sdi, sdo, init_busy, conv_busy, ref_enable;
   logic [11:0] adc_code, code;
   logic [2:0] adc_chan, ch;
   logic [7:0] pin_pulldown, pin_adc_sel, dac_powerdown, pin_dac_sel, pin_gpi_sel, pin_out, pin_oe;
   logic adc_range, dac_range;
   logic [7:0][11:0] dac_level;
   logic [8:0] d;
   logic [8:0] mem [16];
   logic [11:0] exp_dac [8];
   logic [3:0] a;
   int fail_count, total_checks, cyc, seed, n;
   logic [3:0] regs [10] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // Short power-up count keeps the run brief
   acp_port #(.POWERUP_P(400)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk),
      .sync_b(sync_b), .sdi(sdi), .sdo(sdo), .adc_code(adc_code), .adc_chan(adc_chan),
      .conv_busy(conv_busy), .init_busy(init_busy), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pulldown(pin_pulldown), .pin_adc_sel(pin_adc_sel), .pin_dac_sel(pin_dac_sel),
      .pin_gpi_sel(pin_gpi_sel), .dac_powerdown(dac_powerdown), .ref_enable(ref_enable),
      .adc_range(adc_range), .dac_range(dac_range), .dac_level(dac_level));
   acp_host host_u (.sclk(sclk), .sync_b(sync_b), .sdi(sdi), .sdo(sdo));
   function automatic logic [15:0] ctl(input logic [3:0] ad, input logic [8:0] dd);
      return {1'b0, ad, 2'b00, dd};
   endfunction
   // Expected {levels, enables}; pin seven shows idle while no conversion runs
   function automatic logic [15:0] pins_exp();
      logic [7:0] oe;
      logic [7:0] o;
      oe = mem[8][7:0] & ~mem[13][7:0] & (~mem[12][7:0] | ~mem[9][7:0]);
      o = mem[9][7:0];
      if (mem[8][8]) begin
         oe[7] = 1'b1;
         o[7] = 1'b1;
      end
      return {o, oe};
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic send(input logic [15:0] w);
      @(posedge ref_clk);
      #1.3 host_u.frame(w);
      repeat (30) @(posedge ref_clk);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      seed = 32'hdd02_22e9;
      rst_b = 1'b0;
      adc_code = 12'h000;
      foreach (exp_dac[i]) exp_dac[i] = 12'h000;
      repeat (10) @(posedge ref_clk);
      chk("pulldown", 16'h00ff, {8'h00, pin_pulldown});
      chk("init", 16'h0001, {15'h0, init_busy});
      rst_b <= 1'b1;
      send(ctl(4'h6, 9'h000));
      for (n = 0; n < 600 && init_busy !== 1'b0; n++) @(posedge ref_clk);
      chk("pulldown", 16'h00ff, {8'h00, pin_pulldown});
      $display("test power-up done");
      foreach (regs[k]) begin
         a = regs[k];
         d = 9'($random(seed));
         // Lock bit kept clear so later pin writes land
         if (a == 4'h3) d[7] = 1'b0;
         mem[a] = d;
         send(ctl(a, d));
         if (a == 4'h4) chk("adc_sel", {8'h0, d[7:0]}, {8'h0, pin_adc_sel});
         if (a == 4'h6) chk("pulldown", {8'h0, d[7:0]}, {8'h0, pin_pulldown});
         if (a == 4'hB) chk("pwr_ref", {7'h0, d}, {7'h0, ref_enable, dac_powerdown});
         send(ctl(4'h7, {3'b001, a, 2'b00}));
         send(ctl(4'h0, 9'h000));
         chk("readback", ctl(a, d), host_u.rd);
      end
      chk("dac_sel", {8'h0, mem[5][7:0]}, {8'h0, pin_dac_sel});
      chk("gpi_sel", {8'h0, mem[10][7:0]}, {8'h0, pin_gpi_sel});
      chk("ranges", {14'h0, mem[3][5:4]}, {14'h0, adc_range, dac_range});
      chk("pins", pins_exp(), {pin_out, pin_oe});
      send(ctl(4'hE, 9'($random(seed))));
      send(ctl(4'h0, 9'($random(seed))));
      chk("reserved", ctl(4'hD, mem[13]), host_u.rd);
      send(ctl(4'h3, 9'h080));
      send(ctl(4'h4, ~mem[4]));
      chk("locked", {8'h0, mem[4][7:0]}, {8'h0, pin_adc_sel});
      send(ctl(4'h3, 9'h000));
      $display("test registers done");
      send(ctl(4'h5, 9'h00F));
      repeat (6) begin
         ch = 3'($random(seed));
         code = 12'($random(seed));
         send({1'b1, ch, code});
         if (ch < 3'd4) exp_dac[ch] = code;
         chk("dac_level", {4'h0, exp_dac[ch]}, {4'h0, dac_level[ch]});
         send(ctl(4'h1, {4'h0, 2'b11, ch}));
         send(ctl(4'h0, 9'h000));
         chk("dac_rb", {1'b1, ch, exp_dac[ch]}, host_u.rd);
      end
      $display("test output codes done");
      @(posedge ref_clk) adc_code <= 12'($random(seed));
      send(ctl(4'h2, 9'h005));
      send(ctl(4'h0, 9'h000));
      chk("busy", 16'h0001, {15'h0, conv_busy});
      chk("chan0", 16'h0000, {13'h0, adc_chan});
      repeat (150) @(posedge ref_clk);
      send(ctl(4'h0, 9'h000));
      chk("result0", {4'h0, adc_code}, host_u.rd);
      chk("chan2", 16'h0002, {13'h0, adc_chan});
      repeat (150) @(posedge ref_clk);
      $display("test conversions done");
      send(16'h7DAC);
      chk("srst_init", 16'h0001, {15'h0, init_busy});
      chk("srst_pd", 16'h00ff, {8'h00, pin_pulldown});
      chk("srst_dac", 16'h0000, {4'h0, dac_level[ch]});
      $display("test soft reset done");
      close_out();
   end
endmodule // testbench
